// ===== hdl/pgsc_top.sv
// pgsc_top: supply-good gating of host config access and slow clock source selection.
// assumes rst_n_i is the trickle-supply power-on reset and the core clock keeps running
// on trickle power; supply_good_flag_i and all pins are asynchronous and are synchronised.
`timescale 1ns/10ps
module pgsc_top
  import pgsc_pkg::*;
#(
  parameter int unsigned GPI_W = 8
) (
  input wire logic core_clk_i,              // core clock, 10 MHz
  input wire logic rst_n_i,                 // trickle power-on reset, active low
  input wire logic supply_good_flag_i,      // main supply good, async
  input wire logic cfg_ldev_a_i,            // logical device A selected
  input wire logic [7:0] cfg_index_i,       // config register index
  input wire logic [7:0] cfg_wdata_i,       // config write data
  input wire logic cfg_wr_i,                // config write strobe
  input wire logic cfg_rd_i,                // config read strobe
  output logic [7:0] cfg_rdata_o,           // config read data
  input wire logic slow_clock_pin_i,        // external 32.768 kHz pin
  input wire logic kbd_data_line_i,         // keyboard data pin
  input wire logic mouse_data_line_i,       // mouse data pin
  input wire logic ir_receive_i,            // infrared receive pin
  input wire logic ring_indicator_1_n_i,    // ring indicator 1, active low
  input wire logic ring_indicator_2_n_i,    // ring indicator 2, active low
  input wire logic serial2_receive_i,       // serial 2 receive pin
  input wire logic [GPI_W-1:0] gpi_i,       // wake-capable general inputs
  output logic [WK_FIXED+GPI_W-1:0] wake_pins_o, // synchronised wake pins
  input wire logic wake_event_req_i,        // wake logic asserts event
  output logic wake_event_out_n_o,          // wake event output, active low
  output logic wake_event_out_oe_o,         // open-drain enable
  input wire logic ir_tx_ctl_i,             // IR transmit from logic
  input wire logic ir_tx_alt_ctl_i,         // alternate IR transmit from logic
  output logic ir_transmit_o,               // IR transmit pin
  output logic ir_transmit_alt_o,           // alternate IR transmit pin
  input wire logic [1:0] led_ctl_i,         // LED drive from blink logic
  output logic indicator_light_1_o,         // LED 1 pin
  output logic indicator_light_2_o,         // LED 2 pin
  input wire logic ir_hd_timeout_req_i,     // IR half-duplex timeout wanted
  output logic ir_hd_timeout_en_o,          // IR half-duplex timeout enable
  output logic supply_good_o,               // synchronised supply-good
  output logic slow_clock_absent_o,         // configured absent bit
  output logic slow_clk_o,                  // selected slow clock level
  output logic slow_tick_o                  // slow clock rising edge pulse
);

  localparam int unsigned WK_W = WK_FIXED + GPI_W;

  typedef struct packed {
    logic [1:0] sg_sync;
    logic [1:0] ext_sync;
    logic [WK_W-1:0] wk_meta;
    logic [WK_W-1:0] wk_stable;
    logic absent;
    logic [7:0] rdata;
    logic [DIV_W-1:0] div_cnt;
    logic int_lvl;
    logic pme_n;
    logic irtx;
    logic irtx_alt;
    logic [1:0] led;
    logic hd_en;
  } pgsc_reg_t;

  pgsc_reg_t q, d;
  logic [WK_W-1:0] wk_raw;
  logic sg;
  logic hit;
  pgsc_clk_if cs ();

  function automatic logic cfg_hit(input logic ldev, input logic [7:0] idx, input logic good);
    cfg_hit = good && ldev && (idx == SLOW_CLOCK_PRESENCE_IDX);
  endfunction

  assign wk_raw = {gpi_i, serial2_receive_i, ring_indicator_2_n_i, ring_indicator_1_n_i,
                   ir_receive_i, mouse_data_line_i, kbd_data_line_i};
  assign sg = q.sg_sync[1];
  assign hit = cfg_hit(cfg_ldev_a_i, cfg_index_i, sg);

  // =====================================================================
  // next state
  always_comb begin
    d = q;
    d.sg_sync = {q.sg_sync[0], supply_good_flag_i};
    d.ext_sync = {q.ext_sync[0], slow_clock_pin_i};
    d.wk_meta = wk_raw;
    d.wk_stable = q.wk_meta;

    if (hit && cfg_wr_i) begin
      d.absent = cfg_wdata_i[ABSENT_BIT];
    end
    d.rdata = RDATA_RST;
    if (hit && cfg_rd_i) begin
      d.rdata[ABSENT_BIT] = q.absent;
      d.rdata[SRC_INT_BIT] = cs.src_int;
    end

    // internal source parks low once main supply is gone
    // a high phase runs to its end first, so no runt reaches the selector
    if (!sg && !q.int_lvl) begin
      d.div_cnt = '0;
      d.int_lvl = 1'b0;
    end else if (q.div_cnt == DIV_W'(INT_HALF_CYC - 1)) begin
      d.div_cnt = '0;
      d.int_lvl = ~q.int_lvl;
    end else begin
      d.div_cnt = q.div_cnt + DIV_W'(1);
    end

    d.pme_n = ~wake_event_req_i;
    d.irtx = ir_tx_ctl_i;
    d.irtx_alt = ir_tx_alt_ctl_i;
    d.led = led_ctl_i;
    d.hd_en = ir_hd_timeout_req_i & sg;
  end

  // =====================================================================
  // state register
  // trickle reset clears all but pme_n, which it sets high
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{sg_sync: 2'h0, ext_sync: 2'h0, wk_meta: '0, wk_stable: '0,
             absent: ABSENT_RST, rdata: RDATA_RST, div_cnt: '0, int_lvl: 1'b0,
             pme_n: 1'b1, irtx: 1'b0, irtx_alt: 1'b0, led: 2'h0, hd_en: 1'b0};
    end else begin
      q <= d;
    end
  end

  // =====================================================================
  // slow clock source
  // bit picks source
  assign cs.ext_lvl = q.ext_sync[1];
  assign cs.int_lvl = q.int_lvl;
  assign cs.sel_absent = q.absent;

  pgsc_clk_sel u_sel (
    .core_clk_i (core_clk_i),
    .rst_n_i (rst_n_i),
    .cs (cs)
  );

  // =====================================================================
  // outputs
  assign cfg_rdata_o = q.rdata;
  assign wake_pins_o = q.wk_stable;
  // open drain: only drive the low level
  assign wake_event_out_n_o = 1'b0;
  assign wake_event_out_oe_o = ~q.pme_n;
  assign ir_transmit_o = q.irtx;
  assign ir_transmit_alt_o = q.irtx_alt;
  assign indicator_light_1_o = q.led[0];
  assign indicator_light_2_o = q.led[1];
  assign ir_hd_timeout_en_o = q.hd_en & sg;
  assign supply_good_o = sg;
  assign slow_clock_absent_o = q.absent;
  assign slow_clk_o = cs.slow_clk;
  assign slow_tick_o = cs.slow_tick;

endmodule

// ===== hdl/pgsc_pkg.sv
// pgsc_pkg: constants and types for the supply-good gating and slow clock select block.
// assumes a single 10 MHz core clock and one trickle-domain power-on reset.
package pgsc_pkg;

  // =====================================================================
  // clocks
  localparam int unsigned CORE_CLK_HZ = 10_000_000;
  localparam int unsigned SLOW_CLK_HZ = 32_768;
  // longest half period: round down, at least one cycle
  localparam int unsigned INT_HALF_CALC = CORE_CLK_HZ / (2 * SLOW_CLK_HZ);
  localparam int unsigned INT_HALF_CYC = (INT_HALF_CALC < 1) ? 1 : INT_HALF_CALC;
  localparam int unsigned DIV_W = 8;

  // =====================================================================
  // configuration register of logical device A
  localparam logic [7:0] SLOW_CLOCK_PRESENCE_IDX = 8'hF0;
  localparam int unsigned ABSENT_BIT = 0;
  localparam int unsigned SRC_INT_BIT = 1;
  localparam logic ABSENT_RST = 1'b0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // =====================================================================
  // wake-pin bundle layout
  localparam int unsigned WK_KBD = 0;
  localparam int unsigned WK_MOUSE = 1;
  localparam int unsigned WK_IR_RECEIVE = 2;
  localparam int unsigned WK_RI1_N = 3;
  localparam int unsigned WK_RI2_N = 4;
  localparam int unsigned WK_SER2 = 5;
  localparam int unsigned WK_FIXED = 6;

  // gray codes along run -> park -> run
  typedef enum logic [1:0] {
    PGSC_RUN = 2'b00,
    PGSC_PARK = 2'b01
  } pgsc_sel_state_t;

endpackage

// ===== hdl/pgsc_clk_if.sv
// pgsc_clk_if: slow clock source levels and selected output between top and selector.
// assumes both ends sit on core_clk_i.
`timescale 1ns/10ps
interface pgsc_clk_if;
  logic ext_lvl;
  logic int_lvl;
  logic sel_absent;
  logic slow_clk;
  logic slow_tick;
  logic src_int;

  modport ctrl (
    output ext_lvl,
    output int_lvl,
    output sel_absent,
    input slow_clk,
    input slow_tick,
    input src_int
  );
  modport mux (
    input ext_lvl,
    input int_lvl,
    input sel_absent,
    output slow_clk,
    output slow_tick,
    output src_int
  );
endinterface

// ===== hdl/pgsc_clk_sel.sv
// pgsc_clk_sel: glitch-free switch between external and internal slow clock levels.
// assumes its levels are already synchronous to core_clk_i.
`timescale 1ns/10ps
module pgsc_clk_sel
  import pgsc_pkg::*;
(
  input wire logic core_clk_i, // core clock
  input wire logic rst_n_i,    // trickle power-on reset, active low
  pgsc_clk_if.mux cs           // source levels in, selected clock out
);

  typedef struct packed {
    pgsc_sel_state_t st;
    logic cur_int;
    logic out;
    logic tick;
  } pgsc_sel_reg_t;

  pgsc_sel_reg_t q, d;
  logic cur_lvl;
  logic new_lvl;

  assign cur_lvl = q.cur_int ? cs.int_lvl : cs.ext_lvl;
  assign new_lvl = cs.sel_absent ? cs.int_lvl : cs.ext_lvl;

  // =====================================================================
  // source switch
  always_comb begin
    d = q;
    d.tick = 1'b0;
    case (q.st)
      PGSC_RUN: begin
        d.out = cur_lvl;
        if ((cs.sel_absent != q.cur_int) && !cur_lvl) begin
          d.st = PGSC_PARK;
          d.out = 1'b0;
        end
      end
      PGSC_PARK: begin
        d.out = 1'b0;
        if (!new_lvl) begin
          d.cur_int = cs.sel_absent;
          d.st = PGSC_RUN;
        end
      end
      default: begin
        d.st = PGSC_RUN;
        d.out = 1'b0;
      end
    endcase
    d.tick = d.out & ~q.out;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{st: PGSC_RUN, cur_int: ABSENT_RST, out: 1'b0, tick: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign cs.slow_clk = q.out;
  assign cs.slow_tick = q.tick;
  assign cs.src_int = q.cur_int;

endmodule

// ===== bench/pgsc_top_asserts.sv
// pgsc_top_asserts: port-level checks of pgsc_top.
// assumes one clock domain, core_clk_i, with async reset rst_n_i.
`timescale 1ns/10ps
module pgsc_top_asserts (
  input wire logic core_clk_i,         // core clock
  input wire logic rst_n_i,            // reset, active low
  input wire logic cfg_ldev_a_i,       // device A select
  input wire logic [7:0] cfg_index_i,  // index
  input wire logic [7:0] cfg_wdata_i,  // write data
  input wire logic cfg_wr_i,           // write strobe
  input wire logic cfg_rd_i,           // read strobe
  input wire logic [7:0] cfg_rdata_o,  // read data
  input wire logic [1:0] led_ctl_i,    // led drive
  input wire logic indicator_light_1_o, // led 1 pin
  input wire logic ir_hd_timeout_en_o, // timeout enable
  input wire logic supply_good_o,      // synced supply-good
  input wire logic slow_clock_absent_o, // absent bit
  input wire logic slow_clk_o,         // slow clock
  input wire logic slow_tick_o         // slow tick
);
  // ==========================================================
  // properties
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic hit;
  assign hit = supply_good_o && cfg_ldev_a_i && cfg_index_i == 8'hF0;
  a_timeout_gated: assert property (ir_hd_timeout_en_o |-> supply_good_o)
    else $error("timeout enabled without supply good");
  a_wr_refused: assert property (!supply_good_o && cfg_wr_i |=> $stable(slow_clock_absent_o))
    else $error("write taken while supply low");
  a_wr_taken: assert property (hit && cfg_wr_i |=> slow_clock_absent_o == $past(cfg_wdata_i[0]))
    else $error("absent bit not written");
  a_rd_idle: assert property (!cfg_rd_i |=> cfg_rdata_o == 8'h00)
    else $error("read data without read");
  a_rd_value: assert property (hit && cfg_rd_i |=>
    cfg_rdata_o[0] == $past(slow_clock_absent_o) && cfg_rdata_o[7:2] == 6'h00)
    else $error("read data wrong");
  a_led_live: assert property (##1 indicator_light_1_o == $past(led_ctl_i[0]))
    else $error("led 1 does not follow");
  a_tick_edge: assert property (slow_tick_o |-> slow_clk_o && !$past(slow_clk_o))
    else $error("tick not at rising edge");
  a_no_runt: assert property ($changed(slow_clk_o) |=> $stable(slow_clk_o))
    else $error("one-cycle slow clock pulse");
endmodule
bind pgsc_top pgsc_top_asserts pgsc_top_asserts_inst (.*);

// ===== bench/pgsc_clk_src.sv
// pgsc_clk_src: external 32.768 kHz oscillator on the slow clock pin.
// assumes the pin is grounded, not floating, while the source is off.
`timescale 1ns/10ps
module pgsc_clk_src #(
  parameter int HALF_NS = 15259
) (
  input wire logic run_i,  // oscillator fitted
  output logic pin_o       // slow clock pin
);
  // ==========================================================
  // external clock source
  initial begin
    pin_o = 1'b0;
    forever begin
      #HALF_NS;
      pin_o = run_i ? ~pin_o : 1'b0;
    end
  end
endmodule

// ===== bench/pgsc_top_tb.sv
// pgsc_top_tb: config accesses, pin liveness and slow clock source tests.
// assumes 10 MHz clock; inputs change at the falling edge.
`timescale 1ns/10ps
module pgsc_top_tb;
  import pgsc_pkg::*;
  logic core_clk_i = 0, rst_n_i = 0, sg = 0, wr = 0, rd = 0, req = 0, ir = 0, osc = 0, pin;
  logic [7:0] idx = 0, wd = 0, rdat;
  logic [1:0] led = 0;
  logic [13:0] pins = 0, wk;
  logic [7:0] rdo;
  logic oe, won, ten, sgo, abs, sclk, tick, irt, ira, l1, l2;
  int errors = 0, check_count = 0, h, t, i;
  initial forever #50 core_clk_i = ~core_clk_i;
  pgsc_clk_src pgsc_clk_src_inst (.run_i(osc), .pin_o(pin));
  pgsc_top pgsc_top_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .supply_good_flag_i(sg), .cfg_ldev_a_i(1'b1), .cfg_index_i(idx), .cfg_wdata_i(wd),
    .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_rdata_o(rdo), .slow_clock_pin_i(pin),
    .kbd_data_line_i(pins[0]), .mouse_data_line_i(pins[1]), .ir_receive_i(pins[2]),
    .ring_indicator_1_n_i(pins[3]), .ring_indicator_2_n_i(pins[4]),
    .serial2_receive_i(pins[5]), .gpi_i(pins[13:6]), .wake_pins_o(wk),
    .wake_event_req_i(req), .wake_event_out_n_o(won), .wake_event_out_oe_o(oe),
    .ir_tx_ctl_i(ir), .ir_tx_alt_ctl_i(~ir), .ir_transmit_o(irt), .ir_transmit_alt_o(ira),
    .led_ctl_i(led), .indicator_light_1_o(l1), .indicator_light_2_o(l2),
    .ir_hd_timeout_req_i(req), .ir_hd_timeout_en_o(ten), .supply_good_o(sgo),
    .slow_clock_absent_o(abs), .slow_clk_o(sclk), .slow_tick_o(tick));
  // ==========================================================
  // tasks
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // one-cycle strobe; read data stands only in the cycle after
  task automatic acc(input logic w, input logic [7:0] x, input logic [7:0] d);
    idx <= x;
    wd <= d;
    wr <= w;
    rd <= ~w;
    cyc(1);
    rdat = rdo;
    wr <= 0;
    rd <= 0;
    cyc(1);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    cyc(5);
    rst_n_i <= 1;
    cyc(2);
    chk("absent", abs, 0);
    req <= 1;
    acc(1, 8'hF0, 8'h01);
    chk("absent", abs, 0);
    acc(0, 8'hF0, 8'h00);
    chk("rdata", rdat, 8'h00);
    pins <= 14'h2A5A;
    led <= 2'b10;
    ir <= 1;
    cyc(4);
    chk("ir_timeout", ten, 0);
    chk("wake_pins", wk, 14'h2A5A);
    chk("wake_oe", oe, 1);
    chk("wake_level", won, 0);
    chk("supply_good", sgo, 0);
    chk("ir_led", {l2, l1, irt, ira}, 4'hA);
    $display("test supply low done");
    sg <= 1;
    osc <= 1;
    cyc(4);
    chk("ir_timeout", ten, 1);
    chk("supply_good", sgo, 1);
    t = 0;
    repeat (1000) begin
      cyc(1);
      t += tick;
    end
    chk("ext_ticks", t >= 3, 1);
    acc(1, 8'hE0, 8'h01);
    chk("absent", abs, 0);
    // pin grounded, so software marks the clock absent
    osc <= 0;
    acc(1, 8'hF0, 8'h01);
    chk("absent", abs, 1);
    for (i = 0; i < 700 && !tick; i++) cyc(1);
    if (i == 700) begin
      errors++;
      stop_test;
    end
    for (h = 0; h < 400 && sclk; h++) cyc(1);
    chk("int_half", h, INT_HALF_CYC);
    acc(0, 8'hF0, 8'h00);
    chk("rdata", rdat, 8'h03);
    $display("test source switch done");
    sg <= 0;
    cyc(4);
    chk("absent", abs, 1);
    chk("ir_timeout", ten, 0);
    chk("supply_good", sgo, 0);
    req <= 0;
    cyc(2);
    chk("wake_oe", oe, 0);
    rst_n_i <= 0;
    cyc(2);
    rst_n_i <= 1;
    cyc(2);
    chk("absent", abs, 0);
    $display("test trickle reset done");
    stop_test;
  end
endmodule
